// ---- hecd_pkg.sv ----
// Constants for the hub configuration image decoder.
// Assumes a byte-wide image read from an external serial memory by a fetch engine.
package hecd_pkg;
  localparam logic [7:0] LOAD_CODE = 8'hd4;
  localparam logic [7:0] WP_CODE = 8'h42;
  localparam logic [7:0] HUB_DESC_TYPE = 8'h29;
  localparam logic [7:0] ZERO_DESC_TYPE = 8'h00;
  localparam logic [7:0] STR_DESC_TYPE = 8'h03;
  localparam logic [15:0] IDX_HUBOPT = 16'h0011;
  localparam logic [15:0] IDX_LEDOPT = 16'h0012;
  localparam logic [15:0] IDX_WP = 16'h0013;
  localparam logic [15:0] IDX_LANGS = 16'h0014;
  localparam logic [15:0] IDX_STRMAP = 16'h0015;
  localparam logic [15:0] IDX_PORTS = 16'h0016;
  localparam logic [15:0] IDX_DETACH = 16'h0017;
  localparam logic [15:0] IDX_LANGARR = 16'h0018;
  localparam logic [15:0] IDX_LAST = 16'h0017;
  localparam logic [7:0] DEF_HUBOPT = 8'h80;
  localparam logic [7:0] DEF_LEDOPT = 8'h00;
  localparam logic [7:0] DEF_WP = 8'h00;
  localparam logic [7:0] DEF_LANGS = 8'h00;
  localparam logic [7:0] DEF_STRMAP = 8'h00;
  localparam logic [3:0] DEF_PORTS = 4'hf;
  localparam logic [3:0] DEF_DETACH = 4'hf;
  localparam logic [7:0] MAX_LANGS = 8'h1f;
  localparam int B_ACCZERO = 7;
  localparam int B_COMPOUND = 6;
  localparam int B_FSONLY = 5;
  localparam int B_NOLED = 4;
  localparam int B_GANG = 2;
  localparam int B_AMBER = 7;
  localparam int B_GREEN = 6;
  localparam int B_SELFPWR = 5;
  localparam int B_MODLED = 4;
  localparam int B_PWRLVL = 3;
  localparam int B_OCLVL = 2;
  localparam int B_OCDIS = 1;
  localparam int B_OCPP = 0;
  localparam int NSTR = 6;
  localparam int CLK_HZ = 20000000;
  localparam int LED_HZ = 120;
  localparam int LED_HALF = CLK_HZ / (2 * LED_HZ);
  localparam logic [31:0] A_STATUS = 32'h0000_0000;
  localparam logic [31:0] A_HUBCHAR = 32'h0000_0004;
  localparam logic [31:0] A_CTRL = 32'h0000_0008;
  localparam logic [31:0] A_OPTS = 32'h0000_000c;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_DONE} hecd_state_e;
endpackage : hecd_pkg

// ---- hecd_sync.sv ----
// Three-stage synchroniser for pin inputs.
// Assumes inputs asynchronous to core_clk; output changes once stages two and three agree.
`timescale 1ns/10ps
module hecd_sync #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] s1Q, s2Q, s3Q, outQ;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
      outQ <= '0;
    end
    else
    begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      for (int i = 0; i < W; i++)
        if (s2Q[i] == s3Q[i])
          outQ[i] <= s3Q[i];
    end
  end
  assign pinOut = outQ;
endmodule : hecd_sync

// ---- hecd_axil.sv ----
// AXI4-Lite slave holding the four register words of the decoder.
// Assumes one outstanding write and one outstanding read; answers a read one cycle after taking it, a write two cycles after.
`timescale 1ns/10ps
module hecd_axil
  import hecd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] statusWord,
  input wire logic [31:0] hubCharWord,
  input wire logic [31:0] optsWord,
  output logic [7:0] ctrlByte,
  output logic ctrlWrite
);
  logic awHeldQ, wHeldQ, bvalidQ, rvalidQ, ctrlWrQ;
  logic awReadyQ, wReadyQ, arReadyQ;
  logic [31:0] awAddrQ, wDataQ, rdataQ;
  logic [3:0] wStrbQ;
  logic [1:0] brespQ, rrespQ;
  logic [7:0] ctrlQ;
  wire awTake = awvalid && !awHeldQ && !bvalidQ;
  wire wTake = wvalid && !wHeldQ && !bvalidQ;
  wire doWrite = awHeldQ && wHeldQ && !bvalidQ;
  wire wrCtrl = awAddrQ[7:0] == A_CTRL[7:0] && awAddrQ[31:8] == '0;
  wire arTake = arvalid && !rvalidQ;
  wire [31:0] rdSel = (araddr == A_STATUS) ? statusWord :
                      (araddr == A_HUBCHAR) ? hubCharWord :
                      (araddr == A_CTRL) ? {24'h000000, ctrlQ} :
                      (araddr == A_OPTS) ? optsWord : 32'h00000000;
  wire rdOk = araddr == A_STATUS || araddr == A_HUBCHAR || araddr == A_CTRL || araddr == A_OPTS;
  wire wrOk = wrCtrl || awAddrQ == A_STATUS || awAddrQ == A_HUBCHAR || awAddrQ == A_OPTS;
  // Next handshake state, so the ready outputs can come straight from flops
  wire awHeldD = !doWrite && (awTake || awHeldQ);
  wire wHeldD = !doWrite && (wTake || wHeldQ);
  wire bvalidD = doWrite || (bvalidQ && !bready);
  wire rvalidD = arTake || (rvalidQ && !rready);
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      bvalidQ <= 1'b0;
      rvalidQ <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
      brespQ <= RESP_OK;
      rrespQ <= RESP_OK;
      rdataQ <= '0;
      ctrlQ <= '0;
      ctrlWrQ <= 1'b0;
      awReadyQ <= 1'b1;
      wReadyQ <= 1'b1;
      arReadyQ <= 1'b1;
    end
    else
    begin
      ctrlWrQ <= 1'b0;
      awReadyQ <= !awHeldD && !bvalidD;
      wReadyQ <= !wHeldD && !bvalidD;
      arReadyQ <= !rvalidD;
      if (awTake)
      begin
        awHeldQ <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wTake)
      begin
        wHeldQ <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite)
      begin
        awHeldQ <= 1'b0;
        wHeldQ <= 1'b0;
        bvalidQ <= 1'b1;
        brespQ <= wrOk ? RESP_OK : RESP_ERR;
        if (wrCtrl && wStrbQ[0])
        begin
          ctrlQ <= wDataQ[7:0];
          ctrlWrQ <= 1'b1;
        end
      end
      else if (bvalidQ && bready)
        bvalidQ <= 1'b0;
      if (arTake)
      begin
        rvalidQ <= 1'b1;
        rdataQ <= rdSel;
        rrespQ <= rdOk ? RESP_OK : RESP_ERR;
      end
      else if (rvalidQ && rready)
        rvalidQ <= 1'b0;
    end
  end
  assign awready = awReadyQ;
  assign wready = wReadyQ;
  assign bvalid = bvalidQ;
  assign bresp = brespQ;
  assign arready = arReadyQ;
  assign rvalid = rvalidQ;
  assign rdata = rdataQ;
  assign rresp = rrespQ;
  assign ctrlByte = ctrlQ;
  assign ctrlWrite = ctrlWrQ;
endmodule : hecd_axil

// ---- hecd_decode.sv ----
// Hub configuration image decoder: fetches byte 0 and, if it holds the load code, bytes 17..23 after reset, then
// serves hub descriptor fields, pin levels, string index and string address lookups.
// Assumes a byte fetch engine (memRd/memAddr -> memValid/memData) and AXI4-Lite master.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module hecd_decode
  import hecd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  output logic memRd,
  output logic [15:0] memAddr,
  input wire logic memValid,
  input wire logic [7:0] memData,
  input wire logic memWrReq,
  output logic memWrAllow,
  output logic cfgDone,
  output logic imageValid,
  input wire logic [7:0] descTypeIn,
  input wire logic descReqValid,
  output logic descStall,
  output logic descAccept,
  output logic [15:0] hubCharacteristics,
  output logic [3:0] portCount,
  output logic [3:0] deviceRemovable,
  output logic fullSpeedOnly,
  output logic canRunOnLocalSupply,
  output logic faultDetectEnable,
  output logic faultPerPort,
  input wire logic [3:0] ledAmberOn,
  input wire logic [3:0] ledGreenOn,
  output logic [3:0] amberPin,
  output logic [3:0] greenPin,
  input wire logic [3:0] portPowerOn,
  output logic [3:0] powerPin,
  input wire logic [3:0] faultPinIn,
  output logic [3:0] portFault,
  output logic stringsEnabled,
  output logic [5:0] stringIndexMask,
  input wire logic [2:0] strSel,
  input wire logic [4:0] langSel,
  output logic [15:0] strPtrAddr,
  output logic [15:0] langCodeAddr,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  hecd_state_e stateQ;
  logic [15:0] idxQ;
  logic [7:0] hubOptQ, ledOptQ, wpQ, langsQ, strMapQ;
  logic [3:0] portsQ, detachQ;
  logic validQ, doneQ, rdQ, ledPhaseQ;
  logic [19:0] ledCntQ;
  logic [3:0] faultSync;
  logic [7:0] ctrlByte;
  logic descStallQ, descAcceptQ, wrAllowQ;
  logic [15:0] hubCharQ, strPtrQ, langAddrQ;
  logic [3:0] amberQ, greenQ, powerQ, faultQ, remQ, cntQ;
  logic [5:0] idxMaskQ;
  logic fsQ, selfQ, ocEnQ, ocPpQ, strEnQ;

  function automatic logic [3:0] popCount(input logic [3:0] v);
    popCount = {3'b000, v[0]} + {3'b000, v[1]} + {3'b000, v[2]} + {3'b000, v[3]};
  endfunction : popCount

  // Logical port k maps to the k-th set bit of the usable mask
  function automatic logic [3:0] physFromLogical(input logic [3:0] mask, input logic [3:0] det);
    logic [3:0] r;
    logic [2:0] n;
    r = '0;
    n = '0;
    for (int p = 0; p < 4; p++)
      if (mask[p])
      begin
        r[p] = det[n[1:0]];
        n = n + 3'd1;
      end
    physFromLogical = r;
  endfunction : physFromLogical

  hecd_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pinIn(faultPinIn),
    .pinOut(faultSync)
  );

  // Fetch sequencer
  wire byteIn = stateQ == S_WAIT && memValid;
  wire badCode = byteIn && idxQ == '0 && memData != LOAD_CODE;
  wire lastByte = byteIn && idxQ == IDX_LAST;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      stateQ <= S_IDLE;
      idxQ <= '0;
      rdQ <= 1'b0;
      doneQ <= 1'b0;
      validQ <= 1'b0;
    end
    else
    begin
      rdQ <= 1'b0;
      case (stateQ)
        S_IDLE:
          stateQ <= S_REQ;
        S_REQ:
        begin
          rdQ <= 1'b1;
          stateQ <= S_WAIT;
        end
        S_WAIT:
          if (badCode)
            stateQ <= S_DONE;
          else if (lastByte)
          begin
            validQ <= 1'b1;
            stateQ <= S_DONE;
          end
          else if (byteIn)
          begin
            idxQ <= (idxQ == '0) ? IDX_HUBOPT : idxQ + 16'd1;
            stateQ <= S_REQ;
          end
        S_DONE:
          doneQ <= 1'b1;
        default:
          stateQ <= S_IDLE;
      endcase
    end
  end

  // Captured image bytes, defaults until a valid image lands
  always_ff @(posedge core_clk)
  begin
    if (!resetn || badCode)
    begin
      hubOptQ <= DEF_HUBOPT;
      ledOptQ <= DEF_LEDOPT;
      wpQ <= DEF_WP;
      langsQ <= DEF_LANGS;
      strMapQ <= DEF_STRMAP;
      portsQ <= DEF_PORTS;
      detachQ <= DEF_DETACH;
    end
    else if (byteIn)
    begin
      if (idxQ == IDX_HUBOPT) hubOptQ <= memData;
      if (idxQ == IDX_LEDOPT) ledOptQ <= memData;
      if (idxQ == IDX_WP) wpQ <= memData;
      if (idxQ == IDX_LANGS) langsQ <= memData;
      if (idxQ == IDX_STRMAP) strMapQ <= memData;
      if (idxQ == IDX_PORTS) portsQ <= memData[3:0];
      if (idxQ == IDX_DETACH) detachQ <= memData[3:0];
    end
  end

  // 120 Hz gating wave
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ledCntQ <= '0;
      ledPhaseQ <= 1'b0;
    end
    else if (ledCntQ == 20'(LED_HALF - 1))
    begin
      ledCntQ <= '0;
      ledPhaseQ <= !ledPhaseQ;
    end
    else
      ledCntQ <= ledCntQ + 20'd1;
  end

  wire gang = hubOptQ[B_GANG];
  wire noLed = hubOptQ[B_NOLED];
  wire ocDis = ledOptQ[B_OCDIS];
  wire fsOnly = hubOptQ[B_FSONLY];
  wire wpActive = wpQ == WP_CODE;
  wire strEn = langsQ != 8'h00 && langsQ <= MAX_LANGS;
  wire ledGate = !ledOptQ[B_MODLED] || ledPhaseQ;
  wire [15:0] hubChar = {8'h00, !noLed, 2'b00, ocDis, ledOptQ[B_OCPP],
                         hubOptQ[B_COMPOUND], !gang, !gang};
  wire [3:0] amberOn = ledAmberOn & {4{!noLed && ledGate}};
  wire [3:0] greenOn = ledGreenOn & {4{!noLed && ledGate}};
  wire [3:0] faultRaw = faultSync ^ {4{!ledOptQ[B_OCLVL]}};
  wire [3:0] faultEff = ocDis ? 4'h0 : (ledOptQ[B_OCPP] ? faultRaw : {4{|faultRaw}});
  wire [3:0] pwrOn = gang ? {4{|(portPowerOn & portsQ)}} : portPowerOn & portsQ;
  // Pointer array k starts at 24 + 2N(k+1), entry per language
  wire [15:0] twoN = {7'h00, langsQ, 1'b0};
  wire [15:0] langOff = {10'h000, langSel, 1'b0};
  wire [15:0] arrBase = IDX_LANGARR + twoN * ({13'h0000, strSel} + 16'd1);
  wire zeroReq = descTypeIn == ZERO_DESC_TYPE;
  wire typeOk = descTypeIn == HUB_DESC_TYPE || (zeroReq && hubOptQ[B_ACCZERO]);

  hecd_axil u_axil (
    .core_clk(core_clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .statusWord({27'h0000000, wpActive, strEn, fsOnly, validQ, doneQ}),
    .hubCharWord({16'h0000, hubChar}),
    .optsWord({8'h00, strMapQ, ledOptQ, hubOptQ}),
    .ctrlByte(ctrlByte),
    .ctrlWrite()
  );

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      descStallQ <= 1'b0;
      descAcceptQ <= 1'b0;
      wrAllowQ <= 1'b0;
      hubCharQ <= '0;
      strPtrQ <= '0;
      langAddrQ <= '0;
      amberQ <= '0;
      greenQ <= '0;
      powerQ <= '0;
      faultQ <= '0;
      remQ <= '0;
      cntQ <= '0;
      idxMaskQ <= '0;
      fsQ <= 1'b0;
      selfQ <= 1'b0;
      ocEnQ <= 1'b0;
      ocPpQ <= 1'b0;
      strEnQ <= 1'b0;
    end
    else
    begin
      descStallQ <= descReqValid && doneQ && !typeOk;
      descAcceptQ <= descReqValid && doneQ && typeOk;
      wrAllowQ <= doneQ && !wpActive && memWrReq && !ctrlByte[0];
      hubCharQ <= hubChar;
      strPtrQ <= (strEn && strSel < 3'(NSTR)) ? arrBase + langOff : 16'h0000;
      langAddrQ <= IDX_LANGARR + langOff;
      amberQ <= amberOn ^ {4{!ledOptQ[B_AMBER]}};
      greenQ <= greenOn ^ {4{!ledOptQ[B_GREEN]}};
      powerQ <= pwrOn ^ {4{!ledOptQ[B_PWRLVL]}};
      faultQ <= faultEff & portsQ;
      remQ <= physFromLogical(portsQ, detachQ);
      cntQ <= popCount(portsQ);
      idxMaskQ <= strEn ? strMapQ[NSTR-1:0] : 6'h00;
      fsQ <= fsOnly;
      selfQ <= ledOptQ[B_SELFPWR];
      ocEnQ <= !ocDis;
      ocPpQ <= ledOptQ[B_OCPP];
      strEnQ <= strEn;
    end
  end

  assign memRd = rdQ;
  assign memAddr = idxQ;
  assign cfgDone = doneQ;
  assign imageValid = validQ;
  assign descStall = descStallQ;
  assign descAccept = descAcceptQ;
  assign memWrAllow = wrAllowQ;
  assign hubCharacteristics = hubCharQ;
  assign portCount = cntQ;
  assign deviceRemovable = remQ;
  assign fullSpeedOnly = fsQ;
  assign canRunOnLocalSupply = selfQ;
  assign faultDetectEnable = ocEnQ;
  assign faultPerPort = ocPpQ;
  assign amberPin = amberQ;
  assign greenPin = greenQ;
  assign powerPin = powerQ;
  assign portFault = faultQ;
  assign stringsEnabled = strEnQ;
  assign stringIndexMask = idxMaskQ;
  assign strPtrAddr = strPtrQ;
  assign langCodeAddr = langAddrQ;

  stall_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    descReqValid && doneQ && zeroReq && !hubOptQ[B_ACCZERO] |=> descStall && !descAccept)
    else $error("zero type not stalled");
  accept_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    descReqValid && doneQ && zeroReq && hubOptQ[B_ACCZERO] |=> descAccept && !descStall)
    else $error("zero type not accepted");
  compound_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 hubCharacteristics[2] == $past(hubOptQ[B_COMPOUND]))
    else $error("compound bit wrong");
  led_present_a: assert property (@(posedge core_clk) disable iff (!resetn)
    noLed && $stable(noLed) |=> !hubCharacteristics[7] &&
      amberPin == {4{!$past(ledOptQ[B_AMBER])}})
    else $error("indicators not suppressed");
  write_protect_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wpActive |=> !memWrAllow)
    else $error("write allowed under protect");
  str_disable_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (langsQ == 8'h00 || langsQ > MAX_LANGS) |=> stringIndexMask == 6'h00 && strPtrAddr == 16'h0)
    else $error("strings not disabled");
  port_count_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $stable(portsQ) |=> portCount == popCount($past(portsQ)))
    else $error("port count mismatch");
  sequence defaults_s;
    hubOptQ == DEF_HUBOPT && portsQ == DEF_PORTS && detachQ == DEF_DETACH;
  endsequence
  sequence bad_done_s;
    cfgDone && !imageValid;
  endsequence
  bad_image_a: assert property (@(posedge core_clk) disable iff (!resetn)
    badCode |=> defaults_s ##1 bad_done_s)
    else $error("defaults not applied");
  fault_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ocDis |=> portFault == 4'h0)
    else $error("fault seen while disabled");
  fs_only_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 fullSpeedOnly == $past(hubOptQ[B_FSONLY]))
    else $error("full speed flag wrong");
  local_supply_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 canRunOnLocalSupply == $past(ledOptQ[B_SELFPWR]))
    else $error("local supply flag wrong");
  gang_char_a: assert property (@(posedge core_clk) disable iff (!resetn)
    gang |=> hubCharacteristics[1:0] == 2'b00)
    else $error("ganged switching not reported");
  string_mask_a: assert property (@(posedge core_clk) disable iff (!resetn)
    strEn |=> stringIndexMask == $past(strMapQ[NSTR-1:0]))
    else $error("string index mask wrong");
  fault_ports_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 (portFault & ~$past(portsQ)) == 4'h0)
    else $error("fault on unusable port");
endmodule : hecd_decode

// ---- hecd_mem_model.sv ----
// Byte-wide serial memory model that answers the decoder's fetch requests.
// Assumes the bench fills img and sets lat; one request is served at a time.
`timescale 1ns/10ps
module hecd_mem_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic memRd,
  input wire logic [15:0] memAddr,
  output logic memValid,
  output logic [7:0] memData
);
  logic [7:0] img [0:255];
  logic [15:0] seen [$];
  logic [15:0] adr_q;
  logic busy_q;
  int lat = 1;
  int cnt_q;
  always @(posedge core_clk)
  begin
    memValid <= 1'b0;
    // Data line toggles when idle so a stale byte is never seen
    memData <= ~memData;
    if (!resetn)
    begin
      busy_q <= 1'b0;
      memData <= 8'h5a;
      seen.delete();
    end
    else if (busy_q && cnt_q == 0)
    begin
      memValid <= 1'b1;
      memData <= img[adr_q[7:0]];
      busy_q <= 1'b0;
    end
    else if (busy_q)
      cnt_q <= cnt_q - 1;
    else if (memRd)
    begin
      busy_q <= 1'b1;
      adr_q <= memAddr;
      cnt_q <= lat - 1;
      seen.push_back(memAddr);
    end
  end
endmodule : hecd_mem_model

// ---- hecd_decode_tb.sv ----
// Self-checking bench for the configuration image decoder.
// Assumes the memory model as fetch partner and an AXI4-Lite master built from tasks.
`timescale 1ns/10ps
module hecd_decode_tb;
  import hecd_pkg::*;
  logic core_clk = 1'b0;
  logic resetn, memRd, memValid, memWrReq, memWrAllow, cfgDone, imageValid;
  logic descReqValid, descStall, descAccept, fullSpeedOnly, canRunOnLocalSupply;
  logic faultDetectEnable, faultPerPort, stringsEnabled, st, ac;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] memData, descTypeIn;
  logic [15:0] memAddr, hubCharacteristics, strPtrAddr, langCodeAddr;
  logic [3:0] portCount, deviceRemovable, ledAmberOn, ledGreenOn, amberPin, greenPin;
  logic [3:0] portPowerOn, powerPin, faultPinIn, portFault, wstrb;
  logic [5:0] stringIndexMask;
  logic [2:0] strSel;
  logic [4:0] langSel;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int badCount = 0;
  int checksDone = 0;
  hecd_mem_model i_mem (.core_clk, .resetn, .memRd, .memAddr, .memValid, .memData);
  hecd_decode i_dut (.core_clk, .resetn, .memRd, .memAddr, .memValid, .memData,
    .memWrReq, .memWrAllow, .cfgDone, .imageValid, .descTypeIn, .descReqValid,
    .descStall, .descAccept, .hubCharacteristics, .portCount, .deviceRemovable,
    .fullSpeedOnly, .canRunOnLocalSupply, .faultDetectEnable, .faultPerPort,
    .ledAmberOn, .ledGreenOn, .amberPin, .greenPin, .portPowerOn, .powerPin,
    .faultPinIn, .portFault, .stringsEnabled, .stringIndexMask, .strSel, .langSel,
    .strPtrAddr, .langCodeAddr, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);
  always #25 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : look
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Image bytes 0 and 17..23, then reset and wait for the decode to finish
  task automatic boot(input logic [7:0] v [8]);
    @(posedge core_clk);
    resetn <= 1'b0;
    i_mem.img[0] = v[0];
    for (int k = 1; k < 8; k++)
      i_mem.img[16 + k] = v[k];
    i_mem.img[100] = 8'h04;
    i_mem.img[101] = STR_DESC_TYPE;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    look(2);
    chk("cfgDone early", 1'b0, cfgDone);
    while (cfgDone !== 1'b1)
      @(posedge core_clk);
    look(1);
    chk("first fetch", 16'h0000, i_mem.seen[0]);
  endtask : boot
  task automatic desc(input logic [7:0] t);
    @(posedge core_clk);
    descTypeIn <= t;
    descReqValid <= 1'b1;
    @(posedge core_clk);
    descReqValid <= 1'b0;
    st = 1'b0;
    ac = 1'b0;
    repeat (3)
    begin
      @(negedge core_clk);
      st = st | descStall;
      ac = ac | descAccept;
    end
  endtask : desc
  task automatic pins(input logic [3:0] a, g, p, f);
    @(posedge core_clk);
    ledAmberOn <= a;
    ledGreenOn <= g;
    portPowerOn <= p;
    faultPinIn <= f;
    look(6);
  endtask : pins
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge core_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (awready === 1'b1)
        aw = 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (wready === 1'b1)
        w = 1'b0;
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask : axi_rd
  initial
  begin
    repeat (30000) @(posedge core_clk);
    badCount++;
    give_verdict();
  end
  initial
  begin
    resetn = 1'b0;
    memWrReq = 1'b1;
    {descTypeIn, descReqValid, strSel, langSel} = '0;
    {ledAmberOn, ledGreenOn, portPowerOn, faultPinIn} = '0;
    {awaddr, wdata, araddr, awvalid, wvalid, arvalid} = '0;
    {bready, rready, wstrb} = 6'h3f;
    // Bad load code: factory defaults apply whatever follows
    boot('{8'hd0, 8'h00, 8'hff, WP_CODE, 8'h05, 8'h3f, 8'h03, 8'h01});
    chk("imageValid", 1'b0, imageValid);
    chk("hubChar", 16'h0083, hubCharacteristics & 16'h009f);
    chk("portCount", 4'h4, portCount);
    chk("removable", 4'hf, deviceRemovable);
    chk("wrAllow", 1'b1, memWrAllow);
    @(posedge core_clk);
    memWrReq <= 1'b0;
    look(1);
    chk("wrAllow idle", 1'b0, memWrAllow);
    @(posedge core_clk);
    memWrReq <= 1'b1;
    chk("faultEn", 2'b10, {faultDetectEnable, faultPerPort});
    chk("strEn", 1'b0, stringsEnabled);
    desc(ZERO_DESC_TYPE);
    chk("accept zero", 2'b01, {st, ac});
    pins(4'h5, 4'h3, 4'h3, 4'hf);
    chk("amber", 4'ha, amberPin);
    chk("green", 4'hc, greenPin);
    chk("power", 4'hc, powerPin);
    chk("fault", 4'h0, portFault);
    axi_rd(A_STATUS);
    chk("status", 32'h0000_0001, rd);
    // Full image on a slow memory, 31 languages, protect on
    i_mem.lat = 4;
    boot('{LOAD_CODE, 8'h74, 8'h2a, WP_CODE, 8'h1f, 8'h15, 8'h09, 8'h03});
    chk("imageValid", 1'b1, imageValid);
    chk("fetches", 32'd8, i_mem.seen.size());
    chk("last fetch", 16'h0017, i_mem.seen[7]);
    chk("hubChar", 16'h0014, hubCharacteristics & 16'h009f);
    chk("portCount", 4'h2, portCount);
    chk("removable", 4'h9, deviceRemovable);
    chk("fsOnly", 1'b1, fullSpeedOnly);
    chk("local", 1'b1, canRunOnLocalSupply);
    chk("faultEn", 1'b0, faultDetectEnable);
    chk("wrAllow", 1'b0, memWrAllow);
    chk("strEn", 1'b1, stringsEnabled);
    chk("strMask", 6'h15, stringIndexMask);
    desc(ZERO_DESC_TYPE);
    chk("stall zero", 2'b10, {st, ac});
    desc(HUB_DESC_TYPE);
    chk("accept hub", 2'b01, {st, ac});
    pins(4'hf, 4'hf, 4'h1, 4'hf);
    chk("amber off", 4'hf, amberPin);
    chk("green off", 4'hf, greenPin);
    chk("ganged", 4'h9, powerPin & 4'h9);
    chk("fault", 4'h0, portFault);
    for (int s = 0; s < 7; s++)
      for (int l = 0; l < 31; l += 30)
      begin
        @(posedge core_clk);
        strSel <= 3'(s);
        langSel <= 5'(l);
        look(2);
        chk("strPtr", (s > 5) ? 32'd0 : 32'(24 + 62 * (s + 1) + 2 * l), strPtrAddr);
        chk("langAddr", 32'(24 + 2 * l), langCodeAddr);
      end
    axi_rd(A_STATUS);
    chk("status", 32'h0000_001f, rd);
    axi_rd(A_OPTS);
    chk("opts", 32'h0015_2a74, rd);
    axi_rd(32'h0000_0010);
    chk("unmapped rresp", RESP_ERR, rs);
    chk("unmapped rdata", 32'h0, rd);
    // Full image, 32 languages, high LED and fault levels, low power level, modulated leds
    i_mem.lat = 1;
    boot('{LOAD_CODE, 8'h80, 8'hd5, 8'h41, 8'h20, 8'h3f, 8'h06, 8'h01});
    chk("hubChar", 16'h008b, hubCharacteristics & 16'h009f);
    chk("portCount", 4'h2, portCount);
    chk("removable", 4'h2, deviceRemovable);
    chk("levels", 4'b0011, {fullSpeedOnly, canRunOnLocalSupply, faultDetectEnable,
      faultPerPort});
    chk("wrAllow", 1'b1, memWrAllow);
    chk("strOff", 7'h00, {stringsEnabled, stringIndexMask});
    desc(ZERO_DESC_TYPE);
    chk("accept zero", 2'b01, {st, ac});
    @(posedge core_clk);
    strSel <= 3'd0;
    pins(4'h6, 4'h6, 4'h0, 4'h4);
    chk("strPtr off", 16'h0000, strPtrAddr);
    chk("amber gated", 1'b1, amberPin == 4'h6 || amberPin == 4'h0);
    chk("power low", 4'h6, powerPin & 4'h6);
    chk("fault pp", 4'h4, portFault);
    axi_wr(A_CTRL, 32'h1);
    chk("ctrl wr", RESP_OK, rs);
    look(1);
    chk("wr inhibit", 1'b0, memWrAllow);
    axi_rd(A_CTRL);
    chk("ctrl rd", 32'h1, rd);
    axi_wr(32'h0000_0020, 32'h5);
    chk("unmapped wr", RESP_ERR, rs);
    give_verdict();
  end
endmodule : hecd_decode_tb
